// ### inc/scp_consts.vh
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH
// register offsets
`define SCP_ADDR_PORTCFG   8'h00
`define SCP_ADDR_CHIPID    8'h01
`define SCP_ADDR_CHSEL     8'h05
`define SCP_ADDR_POWER     8'h08
`define SCP_ADDR_CLKDIV    8'h0B
`define SCP_ADDR_SHUFFLE   8'h0C
`define SCP_ADDR_TESTPAT   8'h0D
`define SCP_ADDR_OUTMODE   8'h14
`define SCP_ADDR_SHADOW_LO 8'h08
`define SCP_ADDR_SHADOW_HI 8'h3E
`define SCP_ADDR_COMMIT    8'hFF
// reset values
`define SCP_RST_PORTCFG    8'h18
`define SCP_RST_CHSEL      8'hCF
`define SCP_RST_POWER      8'h00
`define SCP_RST_CLKDIV     8'h00
`define SCP_RST_SHUFFLE    8'h01
`define SCP_RST_TESTPAT    8'h00
`define SCP_RST_OUTMODE    8'h00
// fields
`define SCP_PORTCFG_LSB0   6
`define SCP_PORTCFG_LSB1   1
`define SCP_CHSEL_A        0
`define SCP_CHSEL_B        1
`define SCP_TP_MODE_HI     2
`define SCP_TP_SHORT_RST   4
`define SCP_TP_LONG_RST    5
`define SCP_OUT_FMT        0
`define SCP_OUT_INV        2
`define SCP_COMMIT_BIT     0
// frame layout
`define SCP_INSTR_BITS     16
`define SCP_WORD_BITS      8
`define SCP_LEN_STREAM     2'h3
// pattern codes
`define SCP_TP_OFF         3'h0
`define SCP_TP_MID         3'h1
`define SCP_TP_POS         3'h2
`define SCP_TP_NEG         3'h3
`define SCP_TP_CHECK       3'h4
`define SCP_TP_PNLONG      3'h5
`define SCP_TP_PNSHORT     3'h6
// generator seeds
`define SCP_SEED_LONG      23'h7FFFFF
`define SCP_SEED_SHORT     9'h1FF
`endif

// ### rtl/scp_pattern_gen.v
`timescale 1ns/100ps
`include "scp_consts.vh"
module scp_pattern_gen #(
    parameter WIDTH = 11
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             sys_rst,
    // encode clock enable and controls
    input  wire             encodeEn,
    input  wire [2:0]       patternSel,
    input  wire             longHold,
    input  wire             shortHold,
    input  wire             twosComp,
    input  wire             invertOut,
    input  wire [WIDTH-1:0] converterData,
    // formatted output
    output reg  [WIDTH-1:0] dataOut
);
    reg [22:0]       longReg;
    reg [8:0]        shortReg;
    reg              checkReg;
    reg [WIDTH-1:0]  raw;
    reg [WIDTH-1:0]  fmt;
    wire [2*((WIDTH+1)/2)-1:0] checkWide = {(WIDTH+1)/2{checkReg, ~checkReg}};
    wire [17:0]      shortWide = {shortReg, shortReg};

    // generators only step on the encode clock
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            longReg  <= `SCP_SEED_LONG;
            shortReg <= `SCP_SEED_SHORT;
            checkReg <= 1'b0;
        end else begin
            if (longHold)
                longReg <= `SCP_SEED_LONG;
            else if (encodeEn)
                longReg <= {longReg[21:0], longReg[22] ^ longReg[17]};
            if (shortHold)
                shortReg <= `SCP_SEED_SHORT;
            else if (encodeEn)
                shortReg <= {shortReg[7:0], shortReg[8] ^ shortReg[4]};
            if (encodeEn)
                checkReg <= ~checkReg;
        end
    end

    // analog data is ignored in test modes 1 to 6; code 7 passes it through
    always @* begin
        case (patternSel)
            `SCP_TP_OFF:     raw = converterData;
            `SCP_TP_MID:     raw = {1'b1, {(WIDTH-1){1'b0}}};
            `SCP_TP_POS:     raw = {WIDTH{1'b1}};
            `SCP_TP_NEG:     raw = {WIDTH{1'b0}};
            `SCP_TP_CHECK:   raw = checkWide[WIDTH-1:0];
            `SCP_TP_PNLONG:  raw = longReg[WIDTH-1:0];
            `SCP_TP_PNSHORT: raw = shortWide[WIDTH-1:0];
            default:         raw = converterData;
        endcase
        // offset binary to twos complement flips the msb
        fmt = raw ^ {twosComp, {(WIDTH-1){1'b0}}};
        if (invertOut)
            fmt = ~fmt;
    end

    always @(posedge sys_clk) begin
        if (sys_rst)
            dataOut <= {WIDTH{1'b0}};
        else if (encodeEn)
            dataOut <= fmt;
    end
endmodule // scp_pattern_gen

// ### rtl/scp_serial_port.v
`timescale 1ns/100ps
`include "scp_consts.vh"
// Summary of operation
// - test modes 1 to 6 replace converter data with pattern through output formatting; code 7 passes converter data
// - pseudorandom reset bits 4 or 5 hold that generator at its seed
// - patterns ignore analog input and advance only on encode clock
// - frame starts at chip select fall; first clock rise samples instruction
// - chip select held low with length code 3 streams successive bytes indefinitely; other lengths stop after their count
// - chip select may go high between bytes of a counted frame; transfer resumes after, but a stream frame ends there
// - chip select high idles the port and releases data pin
// - every frame begins with a sixteen bit instruction
// - first instruction bit high reads, low writes
// - data phase is whole bytes, count from two length bits
// - reads turn data pin to output after instruction; writes keep input
// - msb first after reset; port config register selects lsb first
// - reset loads critical registers with defaults
// - addresses 08 to 3E are shadowed until commit at FF
// - writing 01 to FF copies all shadows at once, self clears
// - local registers exist per channel, selected by index register
// - writes to local registers update every selected channel
// - reads with both channels selected return channel A copy
// - global registers ignore the channel index
module scp_serial_port #(
    parameter WIDTH   = 11,
    parameter CHIP_ID = 8'h5C  // arbitrary identity value
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             sys_rst,
    // serial pins
    input  wire             serialClk,
    input  wire             chipSelectLow,
    input  wire             dataPinIn,
    output reg              dataPinOut,
    output reg              dataPinOeLow,
    // encode clock and converter data
    input  wire             encodeClk,
    input  wire [WIDTH-1:0] convDataA,
    input  wire [WIDTH-1:0] convDataB,
    // formatted outputs
    output reg  [WIDTH-1:0] outDataA,
    output reg  [WIDTH-1:0] outDataB,
    output reg              testActiveA,
    output reg              testActiveB,
    output reg  [7:0]       activePower,
    output reg  [7:0]       activeClkDiv
);
    localparam ST_INSTR = 2'h0;
    localparam ST_DATA  = 2'h1;
    localparam ST_DONE  = 2'h2;

    wire        sclkS;
    wire        csS;
    wire        sdiS;
    wire        encS;

    reg         sclkPrevReg;
    reg         encPrevReg;
    reg  [1:0]  stateReg;
    reg  [4:0]  bitCntReg;
    reg  [15:0] shiftReg;
    reg         readReg;
    reg  [1:0]  lenReg;
    reg  [12:0] addrReg;
    reg  [2:0]  bytesLeftReg;
    reg  [7:0]  txReg;
    reg         driveReg;
    reg         commitTogReg;
    reg  [2:0]  commitSyncReg;
    reg  [7:0]  portCfgReg;
    reg  [7:0]  chSelReg;
    reg  [7:0]  powerShReg;
    reg  [7:0]  clkDivShReg;
    reg  [7:0]  shufShReg  [0:1];
    reg  [7:0]  testShReg  [0:1];
    reg  [7:0]  outShReg   [0:1];
    reg  [7:0]  shufActReg [0:1];
    reg  [7:0]  testActReg [0:1];
    reg  [7:0]  outActReg  [0:1];
    reg  [7:0]  rdData;
    reg         rdSel;

    wire [WIDTH-1:0] patA;
    wire [WIDTH-1:0] patB;
    // separate loop index per process
    integer     i;
    integer     j;

    // noisy asynchronous pins pass two flops first
    scp_sync2 uSyncClk (.sys_clk(sys_clk), .sys_rst(sys_rst), .asyncIn(serialClk),     .syncOut(sclkS));
    scp_sync2 uSyncCs  (.sys_clk(sys_clk), .sys_rst(sys_rst), .asyncIn(~chipSelectLow), .syncOut(csS));
    scp_sync2 uSyncDi  (.sys_clk(sys_clk), .sys_rst(sys_rst), .asyncIn(dataPinIn),     .syncOut(sdiS));
    scp_sync2 uSyncEnc (.sys_clk(sys_clk), .sys_rst(sys_rst), .asyncIn(encodeClk),     .syncOut(encS));

    wire sclkRise = csS & sclkS & ~sclkPrevReg;
    wire sclkFall = csS & ~sclkS & sclkPrevReg;
    wire encRise  = encS & ~encPrevReg;

    wire lsbFirst = portCfgReg[`SCP_PORTCFG_LSB0] | portCfgReg[`SCP_PORTCFG_LSB1];
    wire [15:0] instrNext = {shiftReg[14:0], sdiS};
    wire [7:0]  byteIn = lsbFirst ? {sdiS, shiftReg[7:1]} : {shiftReg[6:0], sdiS};
    wire [7:0]  wAddr = addrReg[7:0];
    wire        isLocal = (wAddr == `SCP_ADDR_SHUFFLE) | (wAddr == `SCP_ADDR_TESTPAT) | (wAddr == `SCP_ADDR_OUTMODE);

    // read mux; channel A wins when both selected
    always @* begin
        rdSel  = chSelReg[`SCP_CHSEL_A] ? 1'b0 : 1'b1;
        rdData = 8'h00;
        case (wAddr)
            `SCP_ADDR_PORTCFG: rdData = portCfgReg;
            `SCP_ADDR_CHIPID:  rdData = CHIP_ID;
            `SCP_ADDR_CHSEL:   rdData = chSelReg;
            `SCP_ADDR_POWER:   rdData = powerShReg;
            `SCP_ADDR_CLKDIV:  rdData = clkDivShReg;
            `SCP_ADDR_SHUFFLE: rdData = shufShReg[rdSel];
            `SCP_ADDR_TESTPAT: rdData = testShReg[rdSel];
            `SCP_ADDR_OUTMODE: rdData = outShReg[rdSel];
            default:           rdData = 8'h00;
        endcase
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            sclkPrevReg  <= 1'b0;
            encPrevReg   <= 1'b0;
            stateReg     <= ST_INSTR;
            bitCntReg    <= 5'h00;
            shiftReg     <= 16'h0000;
            readReg      <= 1'b0;
            lenReg       <= 2'h0;
            addrReg      <= 13'h0000;
            bytesLeftReg <= 3'h0;
            txReg        <= 8'h00;
            driveReg     <= 1'b0;
            dataPinOut   <= 1'b0;
            dataPinOeLow <= 1'b1;
            commitTogReg <= 1'b0;
            portCfgReg   <= `SCP_RST_PORTCFG & 8'hBD;
            chSelReg     <= `SCP_RST_CHSEL;
            powerShReg   <= `SCP_RST_POWER;
            clkDivShReg  <= `SCP_RST_CLKDIV;
            for (i = 0; i < 2; i = i + 1) begin
                shufShReg[i] <= `SCP_RST_SHUFFLE;
                testShReg[i] <= `SCP_RST_TESTPAT;
                outShReg[i]  <= `SCP_RST_OUTMODE;
            end
        end else begin
            sclkPrevReg <= csS ? sclkS : 1'b0;
            encPrevReg  <= encS;
            // release pin whenever chip select is high
            dataPinOeLow <= ~(csS & driveReg);
            dataPinOut   <= txReg[lsbFirst ? 0 : 7];

            // frame state is kept across a high chip select between bytes of a counted frame; a stream frame ends
            if (sclkRise) begin
                case (stateReg)
                    ST_INSTR: begin
                        shiftReg  <= instrNext;
                        bitCntReg <= bitCntReg + 5'h01;
                        if (bitCntReg == `SCP_INSTR_BITS - 1) begin
                            readReg      <= instrNext[15];
                            lenReg       <= instrNext[14:13];
                            addrReg      <= instrNext[12:0];
                            bytesLeftReg <= {1'b0, instrNext[14:13]} + 3'h1;
                            bitCntReg    <= 5'h00;
                            stateReg     <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        shiftReg  <= {8'h00, byteIn};
                        bitCntReg <= bitCntReg + 5'h01;
                        if (bitCntReg == `SCP_WORD_BITS - 1) begin
                            bitCntReg <= 5'h00;
                            if (!readReg) begin
                                case (wAddr)
                                    `SCP_ADDR_PORTCFG: portCfgReg <= byteIn;
                                    `SCP_ADDR_CHSEL:   chSelReg   <= byteIn;
                                    `SCP_ADDR_POWER:   powerShReg <= byteIn;
                                    `SCP_ADDR_CLKDIV:  clkDivShReg <= byteIn;
                                    `SCP_ADDR_COMMIT:  commitTogReg <= commitTogReg ^ byteIn[`SCP_COMMIT_BIT];
                                    default:           ;
                                endcase
                                if (isLocal) begin
                                    for (i = 0; i < 2; i = i + 1) begin
                                        if (chSelReg[i]) begin
                                            if (wAddr == `SCP_ADDR_SHUFFLE) shufShReg[i] <= byteIn;
                                            if (wAddr == `SCP_ADDR_TESTPAT) testShReg[i] <= byteIn;
                                            if (wAddr == `SCP_ADDR_OUTMODE) outShReg[i]  <= byteIn;
                                        end
                                    end
                                end
                            end
                            // auto decrement address per byte
                            addrReg <= addrReg - 13'h0001;
                            if (lenReg != `SCP_LEN_STREAM) begin
                                bytesLeftReg <= bytesLeftReg - 3'h1;
                                if (bytesLeftReg == 3'h1)
                                    stateReg <= ST_DONE;
                            end
                        end
                    end
                    default: ;
                endcase
            end

            // read data launched on falling edges
            if (sclkFall && stateReg == ST_DATA && readReg) begin
                driveReg <= 1'b1;
                if (bitCntReg == 5'h00)
                    txReg <= rdData;
                else
                    txReg <= lsbFirst ? {1'b0, txReg[7:1]} : {txReg[6:0], 1'b0};
            end
            if (stateReg == ST_DONE)
                driveReg <= 1'b0;

            // whole frame ends only when chip select rises after last byte
            // a stream ends at a byte boundary; a counted frame may pause there
            if (!csS && (stateReg == ST_DONE ||
                (stateReg == ST_DATA && lenReg == `SCP_LEN_STREAM && bitCntReg == 5'h00))) begin
                stateReg  <= ST_INSTR;
                bitCntReg <= 5'h00;
                driveReg  <= 1'b0;
            end
        end
    end

    // commit crossed as a toggle into the encode side
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            commitSyncReg <= 3'h0;
            activePower   <= `SCP_RST_POWER;
            activeClkDiv  <= `SCP_RST_CLKDIV;
            testActiveA   <= 1'b0;
            testActiveB   <= 1'b0;
            for (j = 0; j < 2; j = j + 1) begin
                shufActReg[j] <= `SCP_RST_SHUFFLE;
                testActReg[j] <= `SCP_RST_TESTPAT;
                outActReg[j]  <= `SCP_RST_OUTMODE;
            end
        end else begin
            if (encRise)
                commitSyncReg <= {commitSyncReg[1:0], commitTogReg};

            if (encRise && (commitSyncReg[2] != commitSyncReg[1])) begin
                activePower  <= powerShReg;
                activeClkDiv <= clkDivShReg;
                for (j = 0; j < 2; j = j + 1) begin
                    shufActReg[j] <= shufShReg[j];
                    testActReg[j] <= testShReg[j];
                    outActReg[j]  <= outShReg[j];
                end
            end

            testActiveA <= testActReg[0][`SCP_TP_MODE_HI:0] != `SCP_TP_OFF;
            testActiveB <= testActReg[1][`SCP_TP_MODE_HI:0] != `SCP_TP_OFF;
        end
    end

    scp_pattern_gen #(.WIDTH(WIDTH)) uPatA (
        .sys_clk       (sys_clk),
        .sys_rst       (sys_rst),
        .encodeEn      (encRise),
        .patternSel    (testActReg[0][`SCP_TP_MODE_HI:0]),
        .longHold      (testActReg[0][`SCP_TP_LONG_RST]),
        .shortHold     (testActReg[0][`SCP_TP_SHORT_RST]),
        .twosComp      (outActReg[0][`SCP_OUT_FMT]),
        .invertOut     (outActReg[0][`SCP_OUT_INV]),
        .converterData (convDataA),
        .dataOut       (patA)
    );

    scp_pattern_gen #(.WIDTH(WIDTH)) uPatB (
        .sys_clk       (sys_clk),
        .sys_rst       (sys_rst),
        .encodeEn      (encRise),
        .patternSel    (testActReg[1][`SCP_TP_MODE_HI:0]),
        .longHold      (testActReg[1][`SCP_TP_LONG_RST]),
        .shortHold     (testActReg[1][`SCP_TP_SHORT_RST]),
        .twosComp      (outActReg[1][`SCP_OUT_FMT]),
        .invertOut     (outActReg[1][`SCP_OUT_INV]),
        .converterData (convDataB),
        .dataOut       (patB)
    );

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            outDataA <= {WIDTH{1'b0}};
            outDataB <= {WIDTH{1'b0}};
        end else begin
            outDataA <= patA;
            outDataB <= patB;
        end
    end
endmodule // scp_serial_port

// ### rtl/scp_sync2.v
`timescale 1ns/100ps
module scp_sync2 (
    // clock and reset
    input  wire sys_clk,
    input  wire sys_rst,
    // async level in, synced out
    input  wire asyncIn,
    output reg  syncOut
);
    reg stage1Reg;

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            stage1Reg <= 1'b0;
            syncOut   <= 1'b0;
        end else begin
            stage1Reg <= asyncIn;
            syncOut   <= stage1Reg;
        end
    end
endmodule // scp_sync2

// ### test/scp_host_model.sv
`timescale 1ns/100ps
module scp_host_model (
    // serial pins toward the device
    output logic serialClk,
    output logic chipSelectLow,
    output wire  dataPinIn,
    // device drive of the data pin
    input  wire  dataPinOut,
    input  wire  dataPinOeLow
);
    logic       hostBit;
    logic       hostDrive;
    logic       lsbFirst;
    logic [7:0] wbuf [4];
    logic [7:0] rbuf [4];

    // released wire shows the inverse of the last host level, never a stale copy
    assign dataPinIn = !dataPinOeLow ? dataPinOut : (hostDrive ? hostBit : !hostBit);

    initial begin
        serialClk     = 1'b0;
        chipSelectLow = 1'b1;
        hostBit       = 1'b0;
        hostDrive     = 1'b1;
        lsbFirst      = 1'b0;
        foreach (wbuf[j])
            wbuf[j] = 8'hA5;
    end

    // clock idles low outside frames; data changes only while it is low
    task automatic shiftBit(input logic b, output logic s);
        hostBit = b;
        #40;
        serialClk = 1'b1;
        s = dataPinIn;
        #40;
        serialClk = 1'b0;
    endtask

    task automatic frame(input logic rd, input logic [1:0] len, input logic [12:0] addr, input int n,
                         input logic gap);
        logic [15:0] instr;
        logic        s;
        instr = {rd, len, addr};
        chipSelectLow = 1'b0;
        for (int i = 15; i >= 0; i--)
            shiftBit(instr[i], s);
        hostDrive = !rd;
        for (int k = 0; k < n; k++) begin
            if (gap) begin
                chipSelectLow = 1'b1;
                #200;
                chipSelectLow = 1'b0;
            end
            for (int i = 0; i < 8; i++) begin
                shiftBit(wbuf[k][lsbFirst ? i : 7 - i], s);
                rbuf[k][lsbFirst ? i : 7 - i] = s;
            end
        end
        #40;
        chipSelectLow = 1'b1;
        hostDrive = 1'b1;
        #200;
    endtask
endmodule // scp_host_model

// ### test/scp_serial_port_asserts.sv
`timescale 1ns/100ps
module scp_port_checker #(
    parameter WIDTH = 11
) (
    // clock and reset
    input wire             sys_clk,
    input wire             sys_rst,
    // serial pins
    input wire             serialClk,
    input wire             chipSelectLow,
    input wire             dataPinIn,
    input wire             dataPinOut,
    input wire             dataPinOeLow,
    // encode side
    input wire             encodeClk,
    input wire [WIDTH-1:0] outDataA,
    input wire [WIDTH-1:0] outDataB,
    input wire             testActiveA,
    input wire             testActiveB,
    input wire [7:0]       activePower,
    input wire [7:0]       activeClkDiv
);
    logic       sclk_reg;
    logic       cs_reg;
    logic       enc_reg;
    logic       rwBit_reg;
    logic [5:0] edgeCnt_reg;
    logic [4:0] encIdle_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // count cleared on chip select fall only, so a late release at frame end is not misread
    always @(posedge sys_clk) begin
        sclk_reg <= serialClk;
        cs_reg   <= chipSelectLow;
        enc_reg  <= encodeClk;
        if (sys_rst || encodeClk != enc_reg)
            encIdle_reg <= 5'h00;
        else if (encIdle_reg != 5'h1F)
            encIdle_reg <= encIdle_reg + 5'h01;
        if (sys_rst || (cs_reg && !chipSelectLow))
            edgeCnt_reg <= 6'h00;
        else if (!chipSelectLow && serialClk && !sclk_reg && edgeCnt_reg != 6'h3F) begin
            edgeCnt_reg <= edgeCnt_reg + 6'h01;
            if (edgeCnt_reg == 6'h00)
                rwBit_reg <= dataPinIn;
        end
    end

    a_reset_values: assert property ($fell(sys_rst) |-> dataPinOeLow && !testActiveA && !testActiveB
        && activePower == 8'h00 && activeClkDiv == 8'h00) else $error("outputs not at reset values");
    a_idle_release: assert property (chipSelectLow [*8] |-> dataPinOeLow) else $error("pin driven while idle");
    a_oe_start: assert property ($fell(dataPinOeLow) |-> edgeCnt_reg == 6'd16 && !chipSelectLow)
        else $error("turnaround not after sixteen clocks");
    a_drive_phase: assert property (!dataPinOeLow |-> edgeCnt_reg >= 6'd16) else $error("driven in instruction");
    a_write_quiet: assert property (!dataPinOeLow |-> rwBit_reg) else $error("pin driven in a write");
    a_dout_edge: assert property ($changed(dataPinOut) && !dataPinOeLow |-> !serialClk)
        else $error("read data moved while serial clock high");
    a_enc_outputs: assert property (encIdle_reg > 5'd16 |-> $stable(outDataA) && $stable(outDataB))
        else $error("output moved without encode clock");
    a_enc_commit: assert property (encIdle_reg > 5'd16 |-> $stable({activePower, activeClkDiv, testActiveA, testActiveB}))
        else $error("active copy moved without encode clock");

    c_read: cover property ($fell(dataPinOeLow));
    c_test: cover property ($rose(testActiveA));
    c_stall: cover property (encIdle_reg == 5'h1F && testActiveA);
endmodule // scp_port_checker

bind scp_serial_port scp_port_checker #(.WIDTH(WIDTH)) i_scp_port_checker (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .serialClk(serialClk), .chipSelectLow(chipSelectLow),
    .dataPinIn(dataPinIn), .dataPinOut(dataPinOut), .dataPinOeLow(dataPinOeLow), .encodeClk(encodeClk),
    .outDataA(outDataA), .outDataB(outDataB), .testActiveA(testActiveA), .testActiveB(testActiveB),
    .activePower(activePower), .activeClkDiv(activeClkDiv)
);

// ### test/testbench.sv
`timescale 1ns/100ps
module testbench;
    localparam int         WIDTH   = 11;
    localparam logic [7:0] CHIP_ID = 8'h3C; // arbitrary identity value
    typedef struct {
        logic        wr;
        logic [12:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  exp;
    } scp_row_t;
    logic             sys_clk, sys_rst, encodeClk, encRun, serialClk, chipSelectLow;
    wire              dataPinIn;
    logic             dataPinOut, dataPinOeLow, testActiveA, testActiveB;
    logic [WIDTH-1:0] convDataA, convDataB, outDataA, outDataB, held;
    logic [7:0]       activePower, activeClkDiv, got;
    logic [15:0]      pat [4];
    int               fail_count, samples_checked;
    scp_row_t         rows [10];

    scp_serial_port #(.WIDTH(WIDTH), .CHIP_ID(CHIP_ID)) i_scp_serial_port (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .serialClk(serialClk), .chipSelectLow(chipSelectLow),
        .dataPinIn(dataPinIn), .dataPinOut(dataPinOut), .dataPinOeLow(dataPinOeLow), .encodeClk(encodeClk),
        .convDataA(convDataA), .convDataB(convDataB), .outDataA(outDataA), .outDataB(outDataB),
        .testActiveA(testActiveA), .testActiveB(testActiveB), .activePower(activePower),
        .activeClkDiv(activeClkDiv)
    );
    scp_host_model i_scp_host_model (
        .serialClk(serialClk), .chipSelectLow(chipSelectLow), .dataPinIn(dataPinIn),
        .dataPinOut(dataPinOut), .dataPinOeLow(dataPinOeLow)
    );

    always #2 sys_clk = ~sys_clk;
    always #10 if (encRun) encodeClk = ~encodeClk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        i_scp_host_model.wbuf[0] = d;
        i_scp_host_model.frame(1'b0, 2'h0, a, 1, 1'b0);
    endtask
    task automatic rd(input logic [12:0] a, output logic [7:0] d);
        i_scp_host_model.frame(1'b1, 2'h0, a, 1, 1'b0);
        d = i_scp_host_model.rbuf[0];
    endtask
    // commit crosses into the encode domain, so allow a dozen encode edges
    task automatic commit();
        wr(13'h0FF, 8'h01);
        tick(60);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #300000;
        fail_count++;
        give_verdict();
    end

    initial begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        encodeClk = 1'b0;
        encRun = 1'b1;
        convDataA = 11'h155;
        convDataB = 11'h2AA;
        fail_count = 0;
        samples_checked = 0;
        pat = '{16'h0000, 16'h0400, 16'h07FF, 16'h0000};
        rows = '{'{1'b0, 13'h000, 8'h00, 8'h18}, '{1'b0, 13'h005, 8'h00, 8'hCF}, '{1'b0, 13'h00C, 8'h00, 8'h01},
                 '{1'b0, 13'h00D, 8'h00, 8'h00}, '{1'b0, 13'h014, 8'h00, 8'h00}, '{1'b0, 13'h001, 8'h00, CHIP_ID},
                 '{1'b0, 13'h013, 8'h00, 8'h00}, '{1'b1, 13'h001, 8'hA5, CHIP_ID}, '{1'b1, 13'h00B, 8'h12, 8'h12},
                 '{1'b1, 13'h008, 8'h02, 8'h02}};
        repeat (12) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        tick(4);
        foreach (rows[i]) begin
            if (rows[i].wr)
                wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, got);
            check(16'(got), 16'(rows[i].exp));
        end
        check(16'(activePower), 16'h0000);
        wr(13'h0FF, 8'h01);
        for (int n = 0; n < 200 && activePower !== 8'h02; n++)
            tick(1);
        check(16'(activePower), 16'h0002);
        check(16'(activeClkDiv), 16'h0012);
        rd(13'h0FF, got);
        check(16'(got), 16'h0000);
        for (int c = 1; c <= 6; c++) begin
            wr(13'h00D, 8'(c));
            commit();
            check(16'({testActiveA, testActiveB}), 16'h0003);
            if (c < 4)
                check(16'(outDataA), pat[c]);
            if (c < 4)
                check(16'(outDataB), pat[c]);
        end
        wr(13'h00D, 8'h01);
        wr(13'h014, 8'h01);
        commit();
        check(16'(outDataA), 16'h0000);
        wr(13'h014, 8'h04);
        commit();
        check(16'(outDataA), 16'h03FF);
        wr(13'h014, 8'h00);
        wr(13'h005, 8'h02);
        wr(13'h00D, 8'h00);
        commit();
        check(16'({testActiveA, testActiveB}), 16'h0002);
        check(16'(outDataB), 16'(convDataB));
        wr(13'h005, 8'h03);
        rd(13'h00D, got);
        check(16'(got), 16'h0001);
        wr(13'h005, 8'h02);
        wr(13'h00B, 8'h21);
        rd(13'h00D, got);
        check(16'(got), 16'h0000);
        wr(13'h005, 8'h01);
        rd(13'h00B, got);
        check(16'(got), 16'h0021);
        wr(13'h005, 8'h03);
        for (int k = 0; k < 2; k++) begin
            wr(13'h00D, k ? 8'h25 : 8'h16);
            commit();
            held = outDataA;
            tick(40);
            check(16'(outDataA), 16'(held));
            check(16'(outDataA), 16'h07FF);
            wr(13'h00D, k ? 8'h05 : 8'h06);
            commit();
            held = outDataA;
            tick(25);
            check(16'(outDataA !== held), 16'h0001);
            encRun = 1'b0;
            tick(20);
            held = outDataA;
            tick(100);
            check(16'(outDataA), 16'(held));
            encRun = 1'b1;
        end
        i_scp_host_model.wbuf[0] = 8'h00;
        i_scp_host_model.wbuf[1] = 8'h15;
        i_scp_host_model.frame(1'b0, 2'h1, 13'h00C, 2, 1'b1);
        wr(13'h005, 8'h01);
        i_scp_host_model.frame(1'b1, 2'h3, 13'h00C, 2, 1'b0);
        check({i_scp_host_model.rbuf[0], i_scp_host_model.rbuf[1]}, 16'h0015);
        wr(13'h005, 8'h03);
        wr(13'h000, 8'h5A);
        i_scp_host_model.lsbFirst = 1'b1;
        rd(13'h00B, got);
        check(16'(got), 16'h0015);
        sys_rst = 1'b1;
        tick(3);
        sys_rst = 1'b0;
        tick(4);
        i_scp_host_model.lsbFirst = 1'b0;
        rd(13'h000, got);
        check(16'(got), 16'h0018);
        check({activePower, activeClkDiv}, 16'h0000);
        give_verdict();
    end
endmodule // testbench
